// File: core/srcp_port.sv
`timescale 1ns/10ps
module srcp_port
  import srcp_pkg::*;
#(
  parameter int BIT_CYC_P      = srcp_pkg::BIT_CYC,
  parameter int MS_CYC_P       = srcp_pkg::MS_CYC,
  parameter int BOOT_REMOTE_P  = srcp_pkg::BOOT_REMOTE_MS,
  parameter int BOOT_LOCAL_P   = srcp_pkg::BOOT_LOCAL_MS,
  parameter int DEPTH          = srcp_pkg::LINE_DEPTH,
  parameter int AW             = $clog2(DEPTH)
) (
  // Clock and reset.
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  // Serial lines to host and display.
  input  wire logic               host_rx_in,
  output logic                    host_tx_out,
  output logic                    disp_tx_out,
  // Control source selector and front panel.
  input  wire logic               selector_remote_in,
  input  wire srcp_pkg::srcp_panel_t panel_in,
  output srcp_pkg::srcp_panel_t   panel_out,
  // Live report byte stream.
  input  wire logic [7:0]         rpt_data_in,
  input  wire logic               rpt_valid_in,
  output logic                    rpt_ready_out,
  // Status.
  output logic                    remote_mode_out,
  output logic                    boot_ready_out,
  // Received command line.
  output logic                    cmd_valid_out,
  output logic [AW:0]             cmd_len_out,
  input  wire logic [AW-1:0]      cmd_rd_addr_in,
  output logic [7:0]              cmd_rd_data_out
);

  import srcp_pkg::*;

  localparam logic [13:0] BIT_LAST = 14'(BIT_CYC_P - 1);
  localparam logic [13:0] BIT_HALF = 14'(BIT_CYC_P / 2);
  localparam logic [AW:0] FULL_PTR = (AW + 1)'(DEPTH);

  srcp_uart_state_t rx_state_reg, tx_state_reg;
  logic [13:0] rx_cnt_reg, tx_cnt_reg;
  logic [2:0]  rx_bit_reg, tx_bit_reg;
  logic [7:0]  rx_shift_reg, tx_shift_reg;
  logic [AW:0] wr_ptr_reg;
  logic        prev_cr_reg, ovf_reg;
  logic [2:0]  ack_cnt_reg;
  logic        mode_valid_reg;
  logic [17:0] ms_cnt_reg;
  logic [15:0] boot_ms_reg;

  // Receiver decode.
  wire rx_tick       = (rx_cnt_reg == 14'h0000);
  wire rx_byte_valid = (rx_state_reg == SRCP_STOP) && rx_tick && host_rx_in;
  wire line_end      = rx_byte_valid && (rx_shift_reg == CHAR_LF)
                       && prev_cr_reg;
  wire wr_full       = (wr_ptr_reg == FULL_PTR);
  wire mem_wr        = rx_byte_valid && !line_end && !wr_full;
  wire cmd_fire      = line_end && !ovf_reg && remote_mode_out
                       && boot_ready_out && (ack_cnt_reg == 3'h0);

  // Transmitter source selection; report bytes before acknowledgment.
  wire       tx_tick  = (tx_cnt_reg == 14'h0000);
  wire       tx_idle  = (tx_state_reg == SRCP_IDLE);
  wire       load_rpt = rpt_valid_in && rpt_ready_out;
  wire       load_ack = tx_idle && (ack_cnt_reg != 3'h0) && !load_rpt;
  wire       tx_load  = load_rpt || load_ack;
  wire [7:0] ack_byte = (ack_cnt_reg == 3'h4) ? CHAR_O :
                        (ack_cnt_reg == 3'h3) ? CHAR_K :
                        (ack_cnt_reg == 3'h2) ? CHAR_CR : CHAR_LF;
  wire [7:0] tx_byte  = load_rpt ? rpt_data_in : ack_byte;

  // Boot timer decode.
  wire        ms_tick   = (ms_cnt_reg == 18'(MS_CYC_P - 1));
  wire [15:0] boot_last = remote_mode_out ? 16'(BOOT_REMOTE_P - 1)
                                          : 16'(BOOT_LOCAL_P - 1);

  // Panel gating; only volume, fine tune and squelch pass in remote mode.
  srcp_panel_t panel_gated;
  assign panel_gated.volume    = panel_in.volume;
  assign panel_gated.fine_tune = panel_in.fine_tune;
  assign panel_gated.squelch   = panel_in.squelch;
  assign panel_gated.other     = remote_mode_out ? 5'h00 : panel_in.other;

  // Start-bit hunt, mid-bit sampling and stop check of received bytes.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_state_reg <= SRCP_IDLE;
      rx_cnt_reg   <= 14'h0000;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_cnt_reg <= rx_tick ? BIT_LAST : rx_cnt_reg - 14'h0001;
      case (rx_state_reg)
        SRCP_IDLE: begin
          rx_cnt_reg <= BIT_HALF;
          if (!host_rx_in) begin
            rx_state_reg <= SRCP_START;
          end
        end
        SRCP_START: begin
          if (rx_tick) begin
            rx_bit_reg   <= 3'h0;
            rx_state_reg <= host_rx_in ? SRCP_IDLE : SRCP_DATA;
          end
        end
        SRCP_DATA: begin
          if (rx_tick) begin
            rx_shift_reg <= {host_rx_in, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state_reg <= SRCP_STOP;
            end
          end
        end
        SRCP_STOP: begin
          if (rx_tick) begin
            rx_state_reg <= SRCP_IDLE;
          end
        end
        default: rx_state_reg <= SRCP_IDLE;
      endcase
    end
  end

  // Line assembly; an overlong line is dropped whole at its terminator.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg    <= '0;
      prev_cr_reg   <= 1'b0;
      ovf_reg       <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_len_out   <= '0;
    end else begin
      cmd_valid_out <= cmd_fire;
      if (cmd_fire) begin
        cmd_len_out <= wr_ptr_reg - (AW + 1)'(1);
      end
      if (line_end) begin
        wr_ptr_reg  <= '0;
        prev_cr_reg <= 1'b0;
        ovf_reg     <= 1'b0;
      end else if (rx_byte_valid) begin
        prev_cr_reg <= (rx_shift_reg == CHAR_CR);
        if (wr_full) begin
          ovf_reg <= 1'b1;
        end else begin
          wr_ptr_reg <= wr_ptr_reg + (AW + 1)'(1);
        end
      end
    end
  end

  // Acknowledgment sequencer and report stream handshake.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_cnt_reg   <= 3'h0;
      rpt_ready_out <= 1'b0;
    end else begin
      if (cmd_fire) begin
        ack_cnt_reg <= ACK_LEN;
      end else if (load_ack) begin
        ack_cnt_reg <= ack_cnt_reg - 3'h1;
      end
      rpt_ready_out <= !tx_load && tx_idle && (ack_cnt_reg == 3'h0)
                       && !cmd_fire && boot_ready_out;
    end
  end

  // Transmit framer; one line value feeds host and display alike.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_state_reg <= SRCP_IDLE;
      tx_cnt_reg   <= 14'h0000;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      host_tx_out  <= 1'b1;
      disp_tx_out  <= 1'b1;
    end else begin
      tx_cnt_reg <= tx_tick ? BIT_LAST : tx_cnt_reg - 14'h0001;
      case (tx_state_reg)
        SRCP_IDLE: begin
          tx_cnt_reg <= BIT_LAST;
          if (tx_load) begin
            tx_shift_reg <= tx_byte;
            tx_state_reg <= SRCP_START;
            host_tx_out  <= 1'b0;
            disp_tx_out  <= 1'b0;
          end
        end
        SRCP_START: begin
          if (tx_tick) begin
            host_tx_out  <= tx_shift_reg[0];
            disp_tx_out  <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg   <= 3'h0;
            tx_state_reg <= SRCP_DATA;
          end
        end
        SRCP_DATA: begin
          if (tx_tick) begin
            tx_bit_reg   <= tx_bit_reg + 3'h1;
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            host_tx_out  <= (tx_bit_reg == 3'h7) | tx_shift_reg[0];
            disp_tx_out  <= (tx_bit_reg == 3'h7) | tx_shift_reg[0];
            if (tx_bit_reg == 3'h7) begin
              tx_state_reg <= SRCP_STOP;
            end
          end
        end
        SRCP_STOP: begin
          if (tx_tick) begin
            tx_state_reg <= SRCP_IDLE;
          end
        end
        default: tx_state_reg <= SRCP_IDLE;
      endcase
    end
  end

  // Selector capture on the first edge after reset, then boot timing.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_valid_reg  <= 1'b0;
      remote_mode_out <= 1'b0;
      ms_cnt_reg      <= 18'h00000;
      boot_ms_reg     <= 16'h0000;
      boot_ready_out  <= 1'b0;
      panel_out       <= '0;
    end else begin
      if (!mode_valid_reg) begin
        mode_valid_reg  <= 1'b1;
        remote_mode_out <= selector_remote_in;
      end else if (!boot_ready_out) begin
        ms_cnt_reg <= ms_tick ? 18'h00000 : ms_cnt_reg + 18'h00001;
        if (ms_tick) begin
          boot_ms_reg    <= boot_ms_reg + 16'h0001;
          boot_ready_out <= (boot_ms_reg == boot_last);
        end
      end
      panel_out <= mode_valid_reg ? panel_gated : '0;
    end
  end

  // Line buffer storage with registered read-back.
  srcp_line_mem #(
    .WIDTH (DATA_BITS),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_line_mem (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (mem_wr),
    .wr_addr_in  (wr_ptr_reg[AW-1:0]),
    .wr_data_in  (rx_shift_reg),
    .rd_addr_in  (cmd_rd_addr_in),
    .rd_data_out (cmd_rd_data_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  mode_hold_a: assert property (
      mode_valid_reg |=> $stable(remote_mode_out))
    else $error("Control source changed after power-up.");
  local_cmd_a: assert property (
      !remote_mode_out |-> !cmd_valid_out)
    else $error("Command accepted in local mode.");
  panel_lock_a: assert property (
      remote_mode_out && mode_valid_reg |=> panel_out.other == 5'h00)
    else $error("Locked panel control passed in remote mode.");
  disp_mirror_a: assert property (host_tx_out == disp_tx_out)
    else $error("Display line differs from host line.");
  ack_start_a: assert property (
      cmd_valid_out |-> ack_cnt_reg == 3'h4)
    else $error("No acknowledgment queued for command.");
  // Each implication is bracketed so that neither swallows the other.
  frame_bits_a: assert property (
      ((tx_state_reg == SRCP_START) |-> !host_tx_out)
      and ((tx_state_reg == SRCP_STOP) |-> host_tx_out))
    else $error("Bad start or stop bit level.");
  line_end_a: assert property (
      cmd_valid_out |-> $past(rx_byte_valid)
      && $past(rx_shift_reg) == CHAR_LF)
    else $error("Command taken without line terminator.");
  boot_ready_a: assert property (
      (!mode_valid_reg |-> !boot_ready_out)
      and (boot_ready_out |=> boot_ready_out))
    else $error("Boot ready early or dropped.");

endmodule // srcp_port

// File: core/srcp_pkg.sv
package srcp_pkg;

  // Device clock and serial line rate.
  localparam int CLK_HZ         = 200_000_000;
  localparam int BAUD_RATE      = 19200;
  localparam int DATA_BITS      = 8;

  // Bit period in clock cycles, rounded to the nearest cycle.
  localparam int BIT_CYC        = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;

  // One millisecond in clock cycles, used as the boot timer base.
  localparam int MS_PER_S       = 1000;
  localparam int MS_CYC         = CLK_HZ / MS_PER_S;

  // Boot times in milliseconds for the two control sources.
  localparam int BOOT_REMOTE_MS = 10000;
  localparam int BOOT_LOCAL_MS  = 45000;

  // Command line buffer depth in characters.
  localparam int LINE_DEPTH     = 32;

  // Line terminator and acknowledgment characters.
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_O  = 8'h4F;
  localparam logic [7:0] CHAR_K  = 8'h4B;

  // Number of characters in the acknowledgment string.
  localparam logic [2:0] ACK_LEN = 3'h4;

  // Serial framer states, shared by receiver and transmitter.
  typedef enum logic [1:0] {
    SRCP_IDLE  = 2'b00,
    SRCP_START = 2'b01,
    SRCP_DATA  = 2'b10,
    SRCP_STOP  = 2'b11
  } srcp_uart_state_t;

  // Front-panel control requests.
  typedef struct packed {
    logic [4:0] other;
    logic       squelch;
    logic       fine_tune;
    logic       volume;
  } srcp_panel_t;

endpackage

// File: core/srcp_line_mem.sv
`timescale 1ns/10ps
module srcp_line_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // Write side.
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // Read side.
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Array write; the array itself holds no reset.
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // Registered read port.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule // srcp_line_mem

// File: test/srcp_host_model.sv
`timescale 1ns/10ps
module srcp_host_model #(
  parameter int BIT_CYC_P = 16,
  parameter int GAP_CYC_P = 300
) (
  // Clock.
  input  wire logic clk_in,
  // Serial lines facing the device.
  input  wire logic dev_tx_in,
  output logic      dev_rx_out = 1'b1
);
  logic [7:0] rx_q[$];
  logic [7:0] shift_reg;

  // Sends one frame: start, eight bits LSB first, one stop, no pacing.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      dev_rx_out <= frame[i];
      repeat (BIT_CYC_P - 1) @(posedge clk_in);
    end
  endtask

  // Sends a buffered line with no gaps between characters.
  task automatic send_text(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);
    end
  endtask

  // Sends one command, up to three times, until four answer bytes arrive.
  task automatic send_cmd(input string s, output bit acked);
    int n;
    acked = 1'b0;
    for (int t = 0; t < 3 && !acked; t++) begin
      rx_q.delete();
      send_text(s);
      n = 0;
      while (rx_q.size() < 4 && n < 1500) begin
        @(posedge clk_in);
        n++;
      end
      acked = (rx_q.size() >= 4);
    end
    // The quiet gap starts once the whole answer is in or the third try has timed out.
    repeat (GAP_CYC_P) @(posedge clk_in);
  endtask

  // Receives frames from the device; a byte with a bad stop is dropped.
  initial begin
    forever begin
      @(negedge clk_in);
      if (dev_tx_in === 1'b0) begin
        repeat (BIT_CYC_P / 2) @(negedge clk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC_P) @(negedge clk_in);
          shift_reg[i] = dev_tx_in;
        end
        repeat (BIT_CYC_P) @(negedge clk_in);
        if (dev_tx_in === 1'b1) begin
          rx_q.push_back(shift_reg);
        end
      end
    end
  end
endmodule // srcp_host_model

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
  import srcp_pkg::*;
  localparam int BIT_P = 16;
  localparam int MS_P  = 10;
  localparam int REM_P = 3;
  localparam int LOC_P = 5;
  logic              clk_in, arst_n_in, host_rx, host_tx_out, disp_tx_out;
  logic              selector_remote_in, rpt_valid_in, rpt_ready_out;
  logic              remote_mode_out, boot_ready_out, cmd_valid_out;
  srcp_panel_t       panel_in, panel_out;
  logic [7:0]        rpt_data_in, cmd_rd_data_out, cmd_count, last_len;
  logic [5:0]        cmd_len_out;
  logic [4:0]        cmd_rd_addr_in;
  int                err_total, cmp_count;

  srcp_port #(.BIT_CYC_P(BIT_P), .MS_CYC_P(MS_P), .BOOT_REMOTE_P(REM_P),
    .BOOT_LOCAL_P(LOC_P)) srcp_port_i (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .host_rx_in(host_rx), .host_tx_out(host_tx_out),
    .disp_tx_out(disp_tx_out), .selector_remote_in(selector_remote_in),
    .panel_in(panel_in), .panel_out(panel_out), .rpt_data_in(rpt_data_in),
    .rpt_valid_in(rpt_valid_in), .rpt_ready_out(rpt_ready_out),
    .remote_mode_out(remote_mode_out), .boot_ready_out(boot_ready_out),
    .cmd_valid_out(cmd_valid_out), .cmd_len_out(cmd_len_out),
    .cmd_rd_addr_in(cmd_rd_addr_in), .cmd_rd_data_out(cmd_rd_data_out));

  srcp_host_model #(.BIT_CYC_P(BIT_P), .GAP_CYC_P(30 * MS_P)) host_i (
    .clk_in(clk_in), .dev_tx_in(host_tx_out), .dev_rx_out(host_rx));

  // Free-running clock, 5 ns period.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Counts accepted lines and keeps the last length.
  initial begin
    cmd_count = 8'h00;
    forever begin
      @(negedge clk_in);
      if (cmd_valid_out === 1'b1) begin
        cmd_count = cmd_count + 8'h01;
        last_len = {2'b00, cmd_len_out};
      end
      chk_val(disp_tx_out, host_tx_out);
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Resets with a given selector and times the boot.
  task automatic do_reset(input logic sel, input int boot_ms);
    int n;
    n = 0;
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    selector_remote_in <= sel;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    while (boot_ready_out !== 1'b1 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    chk_val(remote_mode_out, sel);
    chk_val(n >= boot_ms * MS_P, 1'b1);
    chk_val(n <= boot_ms * MS_P + 4, 1'b1);
  endtask

  task automatic read_buf(input logic [4:0] addr, input logic [7:0] exp);
    @(posedge clk_in);
    cmd_rd_addr_in <= addr;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk_val(cmd_rd_data_out, exp);
  endtask

  task automatic test_command();
    bit acked;
    host_i.send_cmd("AB\015\n", acked);
    chk_val(acked, 1'b1);
    chk_val(host_i.rx_q.size() == 4, 1'b1);
    chk_val(host_i.rx_q[0], CHAR_O);
    chk_val(host_i.rx_q[1], CHAR_K);
    chk_val(host_i.rx_q[2], CHAR_CR);
    chk_val(host_i.rx_q[3], CHAR_LF);
    chk_val(cmd_count, 8'h01);
    chk_val(last_len, 8'h02);
    read_buf(5'h00, 8'h41);
    read_buf(5'h02, CHAR_CR);
  endtask

  // A line without terminator waits; the terminator completes it.
  task automatic test_partial();
    bit acked;
    host_i.send_text("XY");
    repeat (400) @(posedge clk_in);
    chk_val(cmd_count, 8'h01);
    host_i.send_cmd("\015\n", acked);
    chk_val(acked, 1'b1);
    chk_val(last_len, 8'h02);
    read_buf(5'h01, 8'h59);
  endtask

  // An overlong line is dropped whole; the next line is taken again.
  task automatic test_overflow();
    bit acked;
    host_i.rx_q.delete();
    host_i.send_text("ABCDEFGHIJKLMNOPQRSTUVWXYZ012345\015\n");
    repeat (1500) @(posedge clk_in);
    chk_val(cmd_count, 8'h02);
    chk_val(host_i.rx_q.size() == 0, 1'b1);
    host_i.send_cmd("Z\015\n", acked);
    chk_val(acked, 1'b1);
    chk_val(cmd_count, 8'h03);
    chk_val(last_len, 8'h01);
  endtask

  task automatic test_panel(input logic [7:0] exp, input logic mode);
    @(posedge clk_in);
    panel_in <= srcp_panel_t'(8'hFF);
    selector_remote_in <= ~mode;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk_val(panel_out, exp);
    chk_val(remote_mode_out, mode);
  endtask

  task automatic test_report();
    int n;
    n = 0;
    host_i.rx_q.delete();
    @(posedge clk_in);
    rpt_data_in <= 8'hA5;
    rpt_valid_in <= 1'b1;
    do begin
      @(negedge clk_in);
      n++;
    end while (rpt_ready_out !== 1'b1 && n < 400);
    @(posedge clk_in);
    rpt_valid_in <= 1'b0;
    repeat (250) @(posedge clk_in);
    chk_val(host_i.rx_q.size() == 1, 1'b1);
    chk_val(host_i.rx_q[0], 8'hA5);
  endtask

  // Local mode: a full command draws neither pulse nor answer.
  task automatic test_local();
    host_i.rx_q.delete();
    host_i.send_text("AB\015\n");
    repeat (1500) @(posedge clk_in);
    chk_val(cmd_count, 8'h03);
    chk_val(host_i.rx_q.size() == 0, 1'b1);
  endtask

  // Main sequence: remote mode first, then a fresh power-up in local mode.
  initial begin
    arst_n_in = 1'b0;
    selector_remote_in = 1'b1;
    panel_in = srcp_panel_t'(8'h00);
    rpt_data_in = 8'h00;
    rpt_valid_in = 1'b0;
    cmd_rd_addr_in = 5'h00;
    do_reset(1'b1, REM_P);
    test_command();
    test_partial();
    test_panel(8'h07, 1'b1);
    test_report();
    test_overflow();
    do_reset(1'b0, LOC_P);
    test_panel(8'hFF, 1'b0);
    test_local();
    test_report();
    conclude();
  end

  // Watchdog well beyond the expected run of about 15000 cycles.
  initial begin
    #150000;
    err_total++;
    conclude();
  end
endmodule // tb
